/* rtl/sbsp_params.svh */
// constants for the synchronous burst sram port: both ends of the link
// assumes inclusion by bare name from rtl files of this block
`ifndef SBSP_PARAMS_SVH
`define SBSP_PARAMS_SVH
// ==========================================================
// widths and sizes
`define SBSP_ADDR_W   8
`define SBSP_DATA_W   32
`define SBSP_LANES    4
`define SBSP_LANE_W   8
`define SBSP_DEPTH    256
// ==========================================================
// defaults of open mode pins
`define SBSP_FT_OPEN  1'b1
`define SBSP_ZZ_OPEN  1'b0
`endif

/* rtl/sbsp_pkg.sv */
// types shared by both ends of the sram port
// assumes sbsp_params.svh is on the include path
`include "sbsp_params.svh"
package sbsp_pkg;
	typedef logic [`SBSP_ADDR_W-1:0] sbsp_addr_t;
	typedef logic [`SBSP_DATA_W-1:0] sbsp_data_t;
	typedef logic [`SBSP_LANES-1:0]  sbsp_lanes_t;
	typedef enum logic {SBSP_LINEAR, SBSP_INTERLEAVED} sbsp_order_e;
endpackage : sbsp_pkg

/* rtl/sbsp_if.sv */
// sram bus between controller and memory device
// assumes one clock, REF_CLK, shared by both ends
`timescale 1ns/1ps
`default_nettype none
`include "sbsp_params.svh"
interface sbsp_if
(
	input wire logic REF_CLK
);
	sbsp_pkg::sbsp_addr_t  addr;
	logic                  proc_addr_strobe_n;
	logic                  ctrl_addr_strobe_n;
	logic                  burst_advance_n;
	logic                  chip_sel_first_n;
	logic                  chip_sel_second;
	logic                  chip_sel_third_n;
	logic                  all_lanes_write_n;
	logic                  lane_write_qual_n;
	sbsp_pkg::sbsp_lanes_t lane_write_n;
	logic                  out_en_n;
	logic                  burst_order_sel_n;
	logic                  flow_through_sel_n;
	logic                  sleep_req;
	logic                  tie_low_pin;
	sbsp_pkg::sbsp_data_t  dq_ctl_o;
	logic                  dq_ctl_oe;
	sbsp_pkg::sbsp_data_t  dq_dev_o;
	logic                  dq_dev_oe;
	sbsp_pkg::sbsp_data_t  dq;
	// bus level resolved from both enables; undriven reads zero
	assign dq = dq_dev_oe ? dq_dev_o : (dq_ctl_oe ? dq_ctl_o : '0);
	modport ctl
	(
		output addr, proc_addr_strobe_n, ctrl_addr_strobe_n, burst_advance_n,
		output chip_sel_first_n, chip_sel_second, chip_sel_third_n,
		output all_lanes_write_n, lane_write_qual_n, lane_write_n, out_en_n,
		output burst_order_sel_n, flow_through_sel_n, sleep_req, tie_low_pin,
		output dq_ctl_o, dq_ctl_oe,
		input  dq
	);
	modport dev
	(
		input  addr, proc_addr_strobe_n, ctrl_addr_strobe_n, burst_advance_n,
		input  chip_sel_first_n, chip_sel_second, chip_sel_third_n,
		input  all_lanes_write_n, lane_write_qual_n, lane_write_n, out_en_n,
		input  burst_order_sel_n, flow_through_sel_n, sleep_req, tie_low_pin,
		output dq_dev_o, dq_dev_oe,
		input  dq
	);
endinterface : sbsp_if
`default_nettype wire

/* rtl/sbsp_dev.sv */
// memory device end: burst counter, byte writes, read paths
// assumes controller keeps mode pins static and drives a legal bus
`timescale 1ns/1ps
`default_nettype none
`include "sbsp_params.svh"
module sbsp_dev
(
	// clock and reset
	input wire logic REF_CLK,
	input wire logic RST_N,
	// sram bus
	sbsp_if.dev      BUS,
	// open-pin indications
	input wire logic FT_OPEN,
	input wire logic ZZ_OPEN,
	// status
	output logic     SLEEPING,
	output logic     PIPELINED
);
	// ==========================================================
	// burst address arithmetic
	function automatic logic [1:0] sbsp_burst_addr(
		input logic [1:0] start,
		input logic [1:0] step,
		input logic       inter);
		if (inter)
			return start ^ step;
		else
			return 2'(start + step);
	endfunction : sbsp_burst_addr
	// ==========================================================
	// state
	sbsp_pkg::sbsp_data_t mem [`SBSP_DEPTH];
	logic [`SBSP_ADDR_W-1:2] upper;
	logic [1:0]              start;
	logic [1:0]              step;
	sbsp_pkg::sbsp_data_t    out_reg;
	logic                    ft_n;
	logic                    zz;
	logic                    zz_s1;
	logic                    zz_s2;
	logic                    oe_s1;
	logic                    oe_s2;
	logic                    sel;
	logic                    strobe;
	logic                    wr;
	logic                    rd_valid;
	logic                    rd_pipe;
	logic [`SBSP_ADDR_W-1:0] cur;
	logic [`SBSP_ADDR_W-1:0] wa;
	sbsp_pkg::sbsp_lanes_t   we;
	// open pins fall back to their pull defaults
	assign ft_n = FT_OPEN ? `SBSP_FT_OPEN : BUS.flow_through_sel_n;
	assign zz   = ZZ_OPEN ? `SBSP_ZZ_OPEN : BUS.sleep_req;
	// async inputs pass two flops before use
	always_ff @(posedge REF_CLK)
	begin
		zz_s1 <= zz;
		zz_s2 <= zz_s1;
		oe_s1 <= BUS.out_en_n;
		oe_s2 <= oe_s1;
	end
	// selection and strobes
	assign sel = !BUS.chip_sel_first_n && BUS.chip_sel_second
		&& !BUS.chip_sel_third_n;
	assign strobe = (!BUS.proc_addr_strobe_n || !BUS.ctrl_addr_strobe_n)
		&& sel && !zz_s2;
	// burst counter; new address may load any cycle while awake
	always_ff @(posedge REF_CLK)
	begin
		if (!RST_N)
		begin
			step  <= 2'h0;
			start <= 2'h0;
			upper <= '0;
		end
		else if (strobe)
		begin
			start <= BUS.addr[1:0];
			upper <= BUS.addr[`SBSP_ADDR_W-1:2];
			step  <= 2'h0;
		end
		else if (!BUS.burst_advance_n && !zz_s2)
			step <= 2'(step + 2'h1);
	end
	assign cur = {upper, sbsp_burst_addr(start, step,
		BUS.burst_order_sel_n)};
	// a write lands where this cycle points, not where the counter was
	assign wa = strobe ? BUS.addr
		: (!BUS.burst_advance_n ? {upper, sbsp_burst_addr(start,
		2'(step + 2'h1), BUS.burst_order_sel_n)} : cur);
	// write decode: global beats qualifier
	always_comb
	begin
		if (!BUS.proc_addr_strobe_n && sel)
			we = '0;
		else if (!BUS.all_lanes_write_n)
			we = '1;
		else if (!BUS.lane_write_qual_n)
			we = ~BUS.lane_write_n;
		else
			we = '0;
	end
	// any write cycle floats the outputs, even one with no lane enabled
	assign wr = !BUS.all_lanes_write_n || !BUS.lane_write_qual_n;
	// memory write per lane; contents kept while asleep
	always_ff @(posedge REF_CLK)
	begin
		if (!zz_s2)
			for (int i = 0; i < `SBSP_LANES; i++)
				if (we[i])
					mem[wa][i*`SBSP_LANE_W +: `SBSP_LANE_W] <=
						BUS.dq[i*`SBSP_LANE_W +: `SBSP_LANE_W];
	end
	// read tracking: burst in progress with no write
	always_ff @(posedge REF_CLK)
	begin
		if (!RST_N)
		begin
			rd_valid <= 1'b0;
			rd_pipe  <= 1'b0;
			out_reg  <= '0;
		end
		else
		begin
			if (strobe)
				rd_valid <= 1'b1;
			else if (!BUS.chip_sel_first_n && !sel)
				rd_valid <= 1'b0;
			rd_pipe <= rd_valid && !wr && !zz_s2;
			out_reg <= mem[cur];
		end
	end
	// flow-through bypasses the output register
	assign BUS.dq_dev_o  = ft_n ? out_reg : mem[cur];
	assign BUS.dq_dev_oe = !oe_s2 && !zz_s2 && !wr
		&& (ft_n ? rd_pipe : rd_valid);
	assign SLEEPING  = zz_s2;
	assign PIPELINED = ft_n;
endmodule : sbsp_dev
`default_nettype wire

/* rtl/sbsp_ctl.sv */
// controller end: drives the sram bus from a simple user port
// assumes device on the far side samples on REF_CLK
`timescale 1ns/1ps
`default_nettype none
`include "sbsp_params.svh"
module sbsp_ctl
(
	// clock and reset
	input wire logic             REF_CLK,
	input wire logic             RST_N,
	// user request
	input wire logic             REQ,
	input wire logic             START,
	input wire logic             WRITE,
	input wire sbsp_pkg::sbsp_addr_t  ADDR,
	input wire sbsp_pkg::sbsp_data_t  WDATA,
	input wire sbsp_pkg::sbsp_lanes_t LANES,
	input wire logic             ALL_LANES,
	// static modes
	input wire logic             INTERLEAVE,
	input wire logic             PIPELINE,
	input wire logic             SLEEP,
	// read data
	output sbsp_pkg::sbsp_data_t RDATA,
	// sram bus
	sbsp_if.ctl                  BUS
);
	// ==========================================================
	// registered bus drive
	always_ff @(posedge REF_CLK)
	begin
		if (!RST_N)
		begin
			BUS.addr               <= '0;
			BUS.proc_addr_strobe_n <= 1'b1;
			BUS.ctrl_addr_strobe_n <= 1'b1;
			BUS.burst_advance_n    <= 1'b1;
			BUS.chip_sel_first_n   <= 1'b1;
			BUS.chip_sel_second    <= 1'b0;
			BUS.chip_sel_third_n   <= 1'b1;
			BUS.all_lanes_write_n  <= 1'b1;
			BUS.lane_write_qual_n  <= 1'b1;
			BUS.lane_write_n       <= '1;
			BUS.dq_ctl_o           <= '0;
			BUS.dq_ctl_oe          <= 1'b0;
			BUS.out_en_n           <= 1'b1;
		end
		else
		begin
			BUS.addr               <= ADDR;
			BUS.proc_addr_strobe_n <= !(REQ && START && !WRITE);
			BUS.ctrl_addr_strobe_n <= !(REQ && START && WRITE);
			BUS.burst_advance_n    <= !(REQ && !START);
			BUS.chip_sel_first_n   <= !(REQ && START);
			BUS.chip_sel_second    <= REQ && START;
			BUS.chip_sel_third_n   <= !(REQ && START);
			BUS.all_lanes_write_n  <= !(REQ && WRITE && ALL_LANES);
			BUS.lane_write_qual_n  <= !(REQ && WRITE);
			BUS.lane_write_n       <= ~LANES;
			BUS.dq_ctl_o           <= WDATA;
			BUS.dq_ctl_oe          <= REQ && WRITE;
			BUS.out_en_n           <= REQ && WRITE;
		end
	end
	// static modes and tie-low pin
	assign BUS.burst_order_sel_n  = INTERLEAVE;
	assign BUS.flow_through_sel_n = PIPELINE;
	assign BUS.sleep_req          = SLEEP;
	assign BUS.tie_low_pin        = 1'b0;
	// capture returned data every cycle
	always_ff @(posedge REF_CLK)
	begin
		if (!RST_N)
			RDATA <= '0;
		else
			RDATA <= BUS.dq;
	end
endmodule : sbsp_ctl
`default_nettype wire

/* testbench/sbsp_properties.sv */
// checker: bus relations between controller and device ends
// assumes instantiation beside sbsp_if, reset synchronous low
`timescale 1ns/1ps
`default_nettype none
// ==================
module sbsp_properties
(
	// clock and reset
	input wire logic REF_CLK,
	input wire logic RST_N,
	// bus controls
	input wire logic proc_addr_strobe_n,
	input wire logic ctrl_addr_strobe_n,
	input wire logic burst_advance_n,
	input wire logic chip_sel_first_n,
	input wire logic chip_sel_second,
	input wire logic chip_sel_third_n,
	input wire logic all_lanes_write_n,
	input wire logic lane_write_qual_n,
	input wire logic out_en_n,
	input wire logic flow_through_sel_n,
	input wire logic sleep_req,
	input wire logic tie_low_pin,
	// data drivers
	input wire logic dq_ctl_oe,
	input wire logic dq_dev_oe
);
	default clocking cb @(posedge REF_CLK); endclocking
	default disable iff (!RST_N);
	// strobe of either kind; a read is a strobe with no write control
	logic st;
	logic rq;
	assign st = !proc_addr_strobe_n || !ctrl_addr_strobe_n;
	assign rq = st && all_lanes_write_n && lane_write_qual_n;
	// three quiet cycles first, since enable and sleep pass two sync flops
	sequence rd_s;
		(!out_en_n && !sleep_req)[*3] ##0 rq;
	endsequence
	a_tie_low_held: assert property (!tie_low_pin)
		else $error("tie-low pin high");
	a_strobe_selects: assert property (st |-> !chip_sel_first_n
		&& chip_sel_second && !chip_sel_third_n) else $error("strobe unselected");
	a_advance_alone: assert property (!burst_advance_n |-> !st)
		else $error("advance with strobe");
	a_global_in_xfer: assert property (!all_lanes_write_n |-> st
		|| !burst_advance_n) else $error("stray global write");
	a_qual_in_xfer: assert property (!lane_write_qual_n |-> st
		|| !burst_advance_n) else $error("stray lane write");
	a_oe_quiet: assert property (out_en_n[*3] |-> !dq_dev_oe)
		else $error("device drives with enable high");
	a_no_clash: assert property (!(dq_dev_oe && dq_ctl_oe))
		else $error("both ends drive data");
	a_pipe_latency: assert property (rd_s ##0 flow_through_sel_n
		|-> ##2 (dq_dev_oe || out_en_n)) else $error("pipelined data late");
	a_flow_latency: assert property (rd_s ##0 !flow_through_sel_n
		|-> ##1 (dq_dev_oe || out_en_n)) else $error("flow data late");
	// main scenarios reached
	c_burst: cover property (st ##1 !burst_advance_n[*4]);
	c_pipe_read: cover property (rd_s ##0 flow_through_sel_n);
	c_flow_read: cover property (rd_s ##0 !flow_through_sel_n);
endmodule : sbsp_properties
`default_nettype wire

/* testbench/testbench.sv */
// bench: both ends joined, shadow memory as the reference
// assumes rtl compiled first and sbsp_params.svh on include path
`timescale 1ns/1ps
`default_nettype none
`include "sbsp_params.svh"
// ==================
module testbench;
	logic                  clk, rst_n, req, start, write, all_lanes;
	logic                  ilv, pipe, slp, ft_open, zz_open;
	logic                  sleeping, pipelined;
	logic [31:0]           seed;
	int                    errors, check_count;
	sbsp_pkg::sbsp_addr_t  addr, a;
	sbsp_pkg::sbsp_lanes_t lanes;
	sbsp_pkg::sbsp_data_t  wdata, rdata, mem [256];
	sbsp_if i_sbsp_if (.REF_CLK(clk));
	sbsp_ctl i_sbsp_ctl (.REF_CLK(clk), .RST_N(rst_n), .REQ(req),
		.START(start), .WRITE(write), .ADDR(addr), .WDATA(wdata),
		.LANES(lanes), .ALL_LANES(all_lanes), .INTERLEAVE(ilv),
		.PIPELINE(pipe), .SLEEP(slp), .RDATA(rdata), .BUS(i_sbsp_if.ctl));
	sbsp_dev i_sbsp_dev (.REF_CLK(clk), .RST_N(rst_n), .BUS(i_sbsp_if.dev),
		.FT_OPEN(ft_open), .ZZ_OPEN(zz_open), .SLEEPING(sleeping),
		.PIPELINED(pipelined));
	sbsp_properties i_sbsp_properties (.REF_CLK(clk), .RST_N(rst_n),
		.proc_addr_strobe_n(i_sbsp_if.proc_addr_strobe_n),
		.ctrl_addr_strobe_n(i_sbsp_if.ctrl_addr_strobe_n),
		.burst_advance_n(i_sbsp_if.burst_advance_n),
		.chip_sel_first_n(i_sbsp_if.chip_sel_first_n),
		.chip_sel_second(i_sbsp_if.chip_sel_second),
		.chip_sel_third_n(i_sbsp_if.chip_sel_third_n),
		.all_lanes_write_n(i_sbsp_if.all_lanes_write_n),
		.lane_write_qual_n(i_sbsp_if.lane_write_qual_n),
		.out_en_n(i_sbsp_if.out_en_n), .sleep_req(i_sbsp_if.sleep_req),
		.flow_through_sel_n(i_sbsp_if.flow_through_sel_n),
		.tie_low_pin(i_sbsp_if.tie_low_pin),
		.dq_ctl_oe(i_sbsp_if.dq_ctl_oe), .dq_dev_oe(i_sbsp_if.dq_dev_oe));
	// ==================
	// reference helpers
	function automatic logic [31:0] lf(input logic [31:0] x);
		lf = x[31] ? (x << 1) ^ 32'h04C11DB7 : x << 1;
	endfunction : lf
	// burst address: upper bits held, low two stepped by order
	function automatic sbsp_pkg::sbsp_addr_t ba(input sbsp_pkg::sbsp_addr_t b,
		input logic [1:0] s, input logic i);
		ba = {b[7:2], i ? b[1:0] ^ s : b[1:0] + s};
	endfunction : ba
	function automatic sbsp_pkg::sbsp_data_t mg(input sbsp_pkg::sbsp_data_t o,
		input sbsp_pkg::sbsp_data_t d, input logic [3:0] l, input logic g);
		mg = o;
		for (int i = 0; i < 4; i++)
			if (g || l[i])
				mg[8*i +: 8] = d[8*i +: 8];
	endfunction : mg
	task automatic chk(input string n, input sbsp_pkg::sbsp_data_t e, g);
		check_count++;
		if (g !== e)
		begin
			errors++;
			$display("BAD %s expected %h seen %h", n, e, g);
		end
	endtask : chk
	// one bus request; req stays up so calls can run back to back
	task automatic op(input logic s, w, input sbsp_pkg::sbsp_addr_t x,
		input sbsp_pkg::sbsp_data_t d, input logic [3:0] l, input logic g);
		@(posedge clk);
		req       <= 1'b1;
		start     <= s;
		write     <= w;
		addr      <= x;
		wdata     <= d;
		lanes     <= l;
		all_lanes <= g;
	endtask : op
	task automatic idle(input int n);
		@(posedge clk);
		req <= 1'b0;
		repeat (n) @(posedge clk);
	endtask : idle
	// latency depends on mode, so the wait before the single check is set by pipe
	task automatic rd(input sbsp_pkg::sbsp_addr_t x);
		op(1'b1, 1'b0, x, '0, 4'h0, 1'b0);
		idle(0);
		// flow data reaches rdata two edges after the strobe, pipelined three
		repeat (pipe ? 4 : 3) @(negedge clk);
		chk("rdata", mem[x], rdata);
	endtask : rd
	task automatic summarize;
		if (errors == 0 && check_count > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask : summarize
	// ==================
	// clock, watchdog and main sequence
	initial
	begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end
	initial
	begin
		#200000;
		errors++;
		summarize();
	end
	initial
	begin
		{rst_n, req, start, write, all_lanes, ilv, pipe, slp} = '0;
		{ft_open, zz_open, addr, wdata, lanes, errors, check_count} = '0;
		seed = 32'h00000D34;
		repeat (8) @(posedge clk);
		rst_n <= 1'b1;
		for (int i = 0; i < 256; i++)
		begin
			seed = lf(seed);
			op(1'b1, 1'b1, i[7:0], seed, 4'h0, 1'b1);
			mem[i] = seed;
		end
		for (int pm = 0; pm < 2; pm++)
		begin
			pipe <= pm[0];
			idle(4);
			repeat (8)
			begin
				seed = lf(seed);
				a = seed[15:8];
				op(1'b1, 1'b1, a, ~seed, seed[3:0], seed[4]);
				mem[a] = mg(mem[a], ~seed, seed[3:0], seed[4]);
				idle(0);
				rd(a);
			end
			// five beats: the fifth wraps onto the start address
			for (int k = 0; k < 8; k++)
			begin
				ilv <= k[2];
				idle(3);
				seed = lf(seed);
				a = {seed[7:2], k[1:0]};
				for (int j = 0; j < 5; j++)
				begin
					op(j == 0, 1'b1, j == 0 ? a : ~a, seed + j, 4'h0, 1'b1);
					mem[ba(a, j[1:0], k[2])] = seed + j;
				end
				idle(0);
				for (int j = 0; j < 4; j++)
					rd(ba(a, j[1:0], k[2]));
			end
		end
		for (int m = 0; m < 8; m++)
		begin
			pipe    <= m[0];
			ft_open <= m[1];
			zz_open <= m[1];
			slp     <= m[2];
			idle(4);
			chk("pipelined", 32'(m[0] | m[1]), 32'(pipelined));
			chk("sleeping", 32'(m[2] & !m[1]), 32'(sleeping));
		end
		{zz_open, ft_open} <= 2'b00;
		idle(4);
		a = seed[7:0];
		op(1'b1, 1'b1, a, ~mem[a], 4'h0, 1'b1);
		idle(0);
		slp <= 1'b0;
		idle(4);
		rd(a);
		summarize();
	end
endmodule : testbench
`default_nettype wire
